/* verilog/dao_defines.vh */
// register offsets, field positions, reset values and timing counts
`ifndef DAO_DEFINES_VH
`define DAO_DEFINES_VH
`define DAO_OFF_CTRL 8'h00
`define DAO_OFF_FMT 8'h04
`define DAO_OFF_DELAY 8'h08
`define DAO_OFF_STAT 8'h0C
`define DAO_OFF_ISTAT 8'h10
`define DAO_OFF_IMASK 8'h14
`define DAO_OFF_DATA 8'h18
// control register fields
`define DAO_CTRL_LPF_LSB 0
`define DAO_CTRL_AGC_EN 8
`define DAO_CTRL_TAP_POST 9
`define DAO_CTRL_EMPH_LSB 10
`define DAO_CTRL_PRESET_LSB 16
// format register fields
`define DAO_FMT_RATE_LSB 0
`define DAO_FMT_SYNC_LSB 4
`define DAO_FMT_WLEN_LSB 8
`define DAO_FMT_DITHER 12
`define DAO_FMT_PRO 13
// delay register fields
`define DAO_DLY_MODE_LSB 0
`define DAO_DLY_MS_LSB 8
// delay modes: 1 to 4 are one frame at 30, 29.97, 25 and 24 fps
`define DAO_DLY_MODE_MIN 3'h0
`define DAO_DLY_MODE_MS 3'h5
// reset values
`define DAO_CTRL_RST 32'h00C8_01C8
`define DAO_FMT_RST 32'h0000_2002
`define DAO_DELAY_RST 32'h0000_1800
// lowpass limits in units of 100 Hz, then ms delay limits in ms
`define DAO_LPF_MIN 8'h64
`define DAO_LPF_MAX 8'hC8
`define DAO_LPF_32K 8'h96
`define DAO_DLY_MIN_MS 8'h18
`define DAO_DLY_MAX_MS 8'h3C
// sample rate codes
`define DAO_RATE_32 3'h0
`define DAO_RATE_44 3'h1
`define DAO_RATE_48 3'h2
`define DAO_RATE_88 3'h3
`define DAO_RATE_96 3'h4
// sync source codes
`define DAO_SYNC_INT 2'h0
`define DAO_SYNC_IN1 2'h1
`define DAO_SYNC_IN2 2'h2
// word length codes
`define DAO_WL_24 3'h0
`define DAO_WL_20 3'h1
`define DAO_WL_18 3'h2
`define DAO_WL_16 3'h3
`define DAO_WL_14 3'h4
// lock qualification time and clock rate
`define DAO_LOCK_QUAL_MS 1000
`define DAO_CLK_KHZ 200000
`define DAO_LOCK_QUAL_CYC (`DAO_LOCK_QUAL_MS * `DAO_CLK_KHZ)
// interrupt bits
`define DAO_IRQ_FALLBACK 0
`define DAO_IRQ_RELOCK 1
`endif

/* verilog/dao_output_config.v */
// digital audio output configuration, sync selection and word shaping
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "dao_defines.vh"

// What this block does
// - bandwidth is the lower of the configured maximum lowpass and preset.
// - a control bit switches the internal gain control stage on or off.
// - the gain-control tap output is taken before or after equalization.
// - delay is minimum, one frame at 30/29.97/25/24 fps, or 24 to 60 ms.
// - output sample rate is 32, 44.1, 48, 88.2 or 96 kHz.
// - at 32 kHz output rate the bandwidth is capped at 15 kHz.
// - timing source is internal, digital input 1 or digital input 2.
// - with external source valid, output rate locks to the input rate.
// - when external lock is unavailable, timing falls back to internal.
// - external sync resumes only after one second of continuous lock.
// - external lock is permitted only when output and input rates match.
// - output words are 24 bits, truncated to 20, 18, 16 or 14 bits.
// - optional high-pass dither is added before truncation, scaled.
// - dither is first-order noise shaped, at most 3 dB above white.
// - channel status is professional or consumer per format setting.
// - preemphasis feeds sidechain and limiter, deemphasized after.
module dao_output_config #(
  parameter LOCK_QUAL_CYC = `DAO_LOCK_QUAL_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire in1_lock,
  input wire [2:0] in1_rate,
  input wire in2_lock,
  input wire [2:0] in2_rate,
  input wire link_clk,
  output reg agc_enable,
  output reg gain_control_tap_route,
  output reg [7:0] lowpass_cutoff,
  output reg [2:0] delay_mode,
  output reg [7:0] delay_ms,
  output reg [1:0] emph_sel,
  output reg emph_sidechain_en,
  output reg emph_deemph_en,
  output reg [2:0] out_rate,
  output reg src_lock_en,
  output reg [1:0] src_sel,
  output reg pro_status,
  output reg [23:0] out_word,
  output reg out_word_valid,
  output reg irq
);

  // ----------------------------------------------------------------
  // configuration registers and bus state
  // ----------------------------------------------------------------
  reg [31:0] ctrl_q;
  reg [31:0] fmt_q;
  reg [31:0] dly_q;
  reg [1:0] istat_q;
  reg [1:0] imask_q;
  reg [23:0] sample_q;
  reg [7:0] awaddr_q;
  reg aw_held_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_held_q;

  // byte lane merge used for the control, format, delay and data registers
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (be[i]) merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  // truncation mask for a word length code
  function [23:0] wl_mask;
    input [2:0] code;
    begin
      case (code)
        `DAO_WL_20: wl_mask = 24'hFFFFF0;
        `DAO_WL_18: wl_mask = 24'hFFFFC0;
        `DAO_WL_16: wl_mask = 24'hFFFF00;
        `DAO_WL_14: wl_mask = 24'hFFFC00;
        default: wl_mask = 24'hFFFFFF;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // synchronisers for pins from outside the clock domain
  // ----------------------------------------------------------------
  reg [8:0] sync1_q;
  reg [8:0] sync2_q;
  reg lclk_prev_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 9'h000;
      sync2_q <= 9'h000;
      lclk_prev_q <= 1'b0;
    end else begin
      sync1_q <= {link_clk, in2_rate, in2_lock, in1_rate, in1_lock};
      sync2_q <= sync1_q;
      lclk_prev_q <= sync2_q[8];
    end
  end
  wire lclk_rise = sync2_q[8] & ~lclk_prev_q;

  // ----------------------------------------------------------------
  // write channel: address and data taken in either order
  // ----------------------------------------------------------------
  wire wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;
  wire ev_fall;
  wire ev_relock;
  wire [1:0] ev_vec = {ev_relock, ev_fall};
  // sample register is 24 bits wide, the merged bus word 32
  wire [31:0] data_mrg = merge({8'h00, sample_q}, wdata_q, wstrb_q);
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      ctrl_q <= `DAO_CTRL_RST;
      fmt_q <= `DAO_FMT_RST;
      dly_q <= `DAO_DELAY_RST;
      imask_q <= 2'h0;
      sample_q <= 24'h000000;
      istat_q <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        aw_held_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_held_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      // event set wins over a write-one clear in the same cycle
      istat_q <= istat_q | ev_vec;
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        case ({awaddr_q[7:2], 2'b00})
          `DAO_OFF_CTRL: ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
          `DAO_OFF_FMT: fmt_q <= merge(fmt_q, wdata_q, wstrb_q);
          `DAO_OFF_DELAY: dly_q <= merge(dly_q, wdata_q, wstrb_q);
          `DAO_OFF_ISTAT:
            if (wstrb_q[0])
              istat_q <= (istat_q & ~wdata_q[1:0]) | ev_vec;
          `DAO_OFF_IMASK: if (wstrb_q[0]) imask_q <= wdata_q[1:0];
          `DAO_OFF_DATA: sample_q <= data_mrg[23:0];
          `DAO_OFF_STAT: s_axi_bresp <= 2'h0;
          default: s_axi_bresp <= 2'h2;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  wire [7:0] cfg_lpf = ctrl_q[`DAO_CTRL_LPF_LSB +: 8];
  wire [7:0] preset_lpf = ctrl_q[`DAO_CTRL_PRESET_LSB +: 8];
  wire [2:0] cfg_rate = fmt_q[`DAO_FMT_RATE_LSB +: 3];
  wire [1:0] cfg_sync = fmt_q[`DAO_FMT_SYNC_LSB +: 2];
  wire [2:0] cfg_wl = fmt_q[`DAO_FMT_WLEN_LSB +: 3];
  wire [2:0] cfg_dmode = dly_q[`DAO_DLY_MODE_LSB +: 3];
  wire [7:0] cfg_dms = dly_q[`DAO_DLY_MS_LSB +: 8];
  // codes above the ms mode fall back to minimum delay
  wire [2:0] dmode_eff = (cfg_dmode > `DAO_DLY_MODE_MS) ? `DAO_DLY_MODE_MIN
                                                        : cfg_dmode;

  // clamp the configured ceiling into its legal span
  wire [7:0] lpf_clamp = (cfg_lpf < `DAO_LPF_MIN) ? `DAO_LPF_MIN :
                         (cfg_lpf > `DAO_LPF_MAX) ? `DAO_LPF_MAX : cfg_lpf;
  wire [7:0] lpf_ceiling = (cfg_rate == `DAO_RATE_32 &&
                            lpf_clamp > `DAO_LPF_32K) ? `DAO_LPF_32K
                                                      : lpf_clamp;
  wire [7:0] lpf_eff = (preset_lpf < lpf_ceiling) ? preset_lpf
                                                  : lpf_ceiling;
  // clamp ms delay to the 24..60 range
  wire [7:0] dms_eff = (cfg_dms < `DAO_DLY_MIN_MS) ? `DAO_DLY_MIN_MS :
                       (cfg_dms > `DAO_DLY_MAX_MS) ? `DAO_DLY_MAX_MS :
                       cfg_dms;

  // ----------------------------------------------------------------
  // sync source qualification state machine
  // ----------------------------------------------------------------
  localparam ST_INT = 2'h0;
  localparam ST_QUAL = 2'h1;
  localparam ST_EXT = 2'h2;
  reg [1:0] st_q;
  reg [31:0] qual_q;
  reg [1:0] sync_cfg_q;
  wire sel_lock = (cfg_sync == `DAO_SYNC_IN1) ? sync2_q[0] :
                  (cfg_sync == `DAO_SYNC_IN2) ? sync2_q[4] : 1'b0;
  wire [2:0] sel_rate = (cfg_sync == `DAO_SYNC_IN2) ? sync2_q[7:5]
                                                    : sync2_q[3:1];
  // rates must match, valid signal present
  wire lock_ok = sel_lock && (sel_rate == cfg_rate) &&
                 (sel_rate <= `DAO_RATE_96);
  assign ev_fall = (st_q == ST_EXT) && !lock_ok;
  assign ev_relock = (st_q == ST_QUAL) &&
                     (qual_q >= LOCK_QUAL_CYC - 1) && lock_ok;
  always @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_INT;
      qual_q <= 32'h0000_0000;
      sync_cfg_q <= 2'h0;
    end else begin
      sync_cfg_q <= cfg_sync;
      case (st_q)
        ST_INT: begin
          qual_q <= 32'h0000_0000;
          if (cfg_sync != `DAO_SYNC_INT && lock_ok) st_q <= ST_QUAL;
        end
        ST_QUAL: begin
          if (!lock_ok || cfg_sync != sync_cfg_q) begin
            st_q <= ST_INT;
            qual_q <= 32'h0000_0000;
          end else if (ev_relock) begin
            st_q <= ST_EXT;
          end else begin
            qual_q <= qual_q + 32'h0000_0001;
          end
        end
        ST_EXT: begin
          if (!lock_ok || cfg_sync != sync_cfg_q) st_q <= ST_INT;
        end
        default: st_q <= ST_INT;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // dither: lfsr noise, first-order high-pass shaping
  // ----------------------------------------------------------------
  reg [15:0] lfsr_q;
  reg [11:0] rnd_prev_q;
  wire [11:0] rnd_now = lfsr_q[11:0];
  // first-difference keeps excess power at most 3 dB over white
  wire [12:0] hp = {1'b0, rnd_now} - {1'b0, rnd_prev_q};
  wire [5:0] wl_shift = (cfg_wl == `DAO_WL_20) ? 6'h03 :
                        (cfg_wl == `DAO_WL_18) ? 6'h05 :
                        (cfg_wl == `DAO_WL_16) ? 6'h07 :
                        (cfg_wl == `DAO_WL_14) ? 6'h09 : 6'h00;
  wire [23:0] dith = (wl_shift == 6'h00) ? 24'h000000 :
                     {{11{hp[12]}}, hp} << wl_shift;
  wire [23:0] dsum = fmt_q[`DAO_FMT_DITHER] ? sample_q + dith
                                            : sample_q;

  // ----------------------------------------------------------------
  // output word per sample tick, status and interrupt outputs
  // ----------------------------------------------------------------
  // ticks come from the link clock for external and internal sources alike
  wire tick = lclk_rise;
  always @(posedge aclk) begin
    if (!aresetn) begin
      lfsr_q <= 16'hACE1;
      rnd_prev_q <= 12'h000;
      out_word <= 24'h000000;
      out_word_valid <= 1'b0;
      agc_enable <= 1'b0;
      gain_control_tap_route <= 1'b0;
      lowpass_cutoff <= `DAO_LPF_MAX;
      delay_mode <= 3'h0;
      delay_ms <= `DAO_DLY_MIN_MS;
      emph_sel <= 2'h0;
      emph_sidechain_en <= 1'b0;
      emph_deemph_en <= 1'b0;
      out_rate <= `DAO_RATE_48;
      src_lock_en <= 1'b0;
      src_sel <= 2'h0;
      pro_status <= 1'b1;
      irq <= 1'b0;
    end else begin
      out_word_valid <= tick;
      if (tick) begin
        lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^
                   lfsr_q[12] ^ lfsr_q[10]};
        rnd_prev_q <= rnd_now;
        out_word <= dsum & wl_mask(cfg_wl);
      end
      agc_enable <= ctrl_q[`DAO_CTRL_AGC_EN];
      gain_control_tap_route <= ctrl_q[`DAO_CTRL_TAP_POST];
      lowpass_cutoff <= lpf_eff;
      delay_mode <= dmode_eff;
      delay_ms <= dms_eff;
      emph_sel <= ctrl_q[`DAO_CTRL_EMPH_LSB +: 2];
      emph_sidechain_en <= ctrl_q[`DAO_CTRL_EMPH_LSB +: 2] != 2'h0;
      emph_deemph_en <= ctrl_q[`DAO_CTRL_EMPH_LSB +: 2] != 2'h0;
      out_rate <= (cfg_rate > `DAO_RATE_96) ? `DAO_RATE_48 : cfg_rate;
      src_lock_en <= (st_q == ST_EXT);
      src_sel <= (st_q == ST_EXT) ? cfg_sync : `DAO_SYNC_INT;
      pro_status <= fmt_q[`DAO_FMT_PRO];
      irq <= |(istat_q & imask_q);
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case ({s_axi_araddr[7:2], 2'b00})
          `DAO_OFF_CTRL: s_axi_rdata <= ctrl_q;
          `DAO_OFF_FMT: s_axi_rdata <= fmt_q;
          `DAO_OFF_DELAY: s_axi_rdata <= dly_q;
          `DAO_OFF_STAT: s_axi_rdata <= {16'h0000, lpf_eff, 4'h0,
                                         lock_ok, st_q, src_lock_en};
          `DAO_OFF_ISTAT: s_axi_rdata <= {30'h0, istat_q};
          `DAO_OFF_IMASK: s_axi_rdata <= {30'h0, imask_q};
          `DAO_OFF_DATA: s_axi_rdata <= {8'h00, sample_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // dao_output_config

/* bench/dao_output_config_chk.sv */
// checker for the audio output configuration block, bound to its top
`timescale 1ns/1ps
`include "dao_defines.vh"
module dao_chk #(
  parameter LOCK_QUAL_CYC = 50
) (
  input logic aclk,
  input logic aresetn,
  input logic in1_lock,
  input logic in2_lock,
  input logic [7:0] lowpass_cutoff,
  input logic [7:0] delay_ms,
  input logic [1:0] emph_sel,
  input logic emph_sidechain_en,
  input logic emph_deemph_en,
  input logic [2:0] out_rate,
  input logic src_lock_en,
  input logic [1:0] src_sel,
  input logic out_word_valid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [31:0] lk_cnt_q;
  // run of cycles with some lock; an upper bound on what the block saw
  always @(posedge aclk) begin
    if (!aresetn || !(in1_lock || in2_lock)) lk_cnt_q <= 32'h0;
    else if (lk_cnt_q != 32'hFFFF_FFFF) lk_cnt_q <= lk_cnt_q + 32'h1;
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_lpf_ceiling: assert property (
    lowpass_cutoff <= `DAO_LPF_MAX) else $error("cutoff above ceiling");
  chk_rate32_cap: assert property (
    (out_rate == `DAO_RATE_32) [*2] |-> lowpass_cutoff <= `DAO_LPF_32K)
    else $error("cutoff not capped at 32k");
  chk_emph_paths: assert property (
    emph_sidechain_en == (emph_sel != 2'h0) &&
    emph_deemph_en == emph_sidechain_en) else $error("emphasis paths");
  chk_delay_range: assert property (
    delay_ms >= `DAO_DLY_MIN_MS && delay_ms <= `DAO_DLY_MAX_MS)
    else $error("delay out of range");
  chk_ext_source: assert property (
    src_lock_en |-> src_sel != `DAO_SYNC_INT) else $error("lock on int");
  chk_fall_back: assert property (
    src_lock_en && src_sel == `DAO_SYNC_IN1 && !in1_lock |->
    ##[1:6] !src_lock_en) else $error("no fallback");
  chk_qual_time: assert property (
    $rose(src_lock_en) |-> lk_cnt_q >= LOCK_QUAL_CYC)
    else $error("lock before qualification");
  chk_word_pulse: assert property (
    out_word_valid |=> !out_word_valid) else $error("word strobe long");
  cover property ($rose(src_lock_en));
  cover property ($fell(src_lock_en));
  cover property (out_word_valid);
endmodule // dao_chk

bind dao_output_config dao_chk #(.LOCK_QUAL_CYC(LOCK_QUAL_CYC)) dao_chk_inst (
  .aclk, .aresetn, .in1_lock, .in2_lock, .lowpass_cutoff, .delay_ms,
  .emph_sel, .emph_sidechain_en, .emph_deemph_en, .out_rate,
  .src_lock_en, .src_sel, .out_word_valid);

/* bench/dao_sync_src.sv */
// model of the sync inputs: lock flags, rate codes and link clock
`timescale 1ns/1ps
module dao_sync_src (
  input logic run,
  input logic lk1,
  input logic lk2,
  input logic [2:0] r1,
  input logic [2:0] r2,
  output logic link_clk,
  output logic in1_lock,
  output logic in2_lock,
  output logic [2:0] in1_rate,
  output logic [2:0] in2_rate
);
  // 80 ns clock, odd phase offset, parked low outside frames
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #40 link_clk = run ? ~link_clk : 1'b0;
  end
  // an unlocked receiver reports garbage, not the last good rate
  assign in1_lock = lk1;
  assign in2_lock = lk2;
  assign in1_rate = lk1 ? r1 : ~r1;
  assign in2_rate = lk2 ? r2 : ~r2;
endmodule // dao_sync_src

/* bench/tb.sv */
// self-checking bench for the audio output configuration block
`timescale 1ns/1ps
`include "dao_defines.vh"
module tb;
  localparam int QUAL = 50;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, agc_enable, gain_control_tap_route, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, emph_sel, src_sel;
  logic [31:0] s_axi_rdata, rdv;
  logic in1_lock, in2_lock, link_clk, emph_sidechain_en, emph_deemph_en;
  logic src_lock_en, pro_status, out_word_valid;
  logic [2:0] in1_rate, in2_rate, out_rate, delay_mode;
  logic run = 1'b0, lk1 = 1'b0, lk2 = 1'b0;
  logic [2:0] r1 = 3'h2, r2 = 3'h2;
  logic [7:0] lowpass_cutoff, delay_ms;
  logic [23:0] out_word;
  logic [1:0] rsp;
  int n_mismatch = 0;
  int checks = 0;
  wire [5:0] cfg_bits = {agc_enable, gain_control_tap_route, emph_sel,
    emph_sidechain_en, emph_deemph_en};
  always #2.5 aclk = ~aclk;
  dao_output_config #(.LOCK_QUAL_CYC(QUAL)) dao_output_config_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .in1_lock, .in1_rate, .in2_lock,
    .in2_rate, .link_clk, .agc_enable, .gain_control_tap_route,
    .lowpass_cutoff, .delay_mode, .delay_ms, .emph_sel,
    .emph_sidechain_en, .emph_deemph_en, .out_rate, .src_lock_en,
    .src_sel, .pro_status, .out_word, .out_word_valid, .irq);
  dao_sync_src dao_sync_src_inst (.run, .lk1, .lk2, .r1, .r2, .link_clk,
    .in1_lock, .in2_lock, .in1_rate, .in2_rate);
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // both write channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    chk(32'(n < 100), 32'h1);
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(32'(n < 100), 32'h1);
    @(posedge aclk);
  endtask
  task automatic wrk(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, rsp);
    chk(rsp, 2'h0);
  endtask
  task automatic rdk(input logic [7:0] a, input logic [31:0] e);
    rd(a, rdv, rsp);
    chk(rsp, 2'h0);
    chk(rdv, e);
  endtask
  task automatic wait_lock(input logic v, input int lim);
    while (src_lock_en !== v && lim > 0) begin
      @(posedge aclk);
      lim--;
    end
    chk(32'(lim > 0), 32'h1);
  endtask
  task automatic wait_word();
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (out_word_valid !== 1'b1 && n < 100);
    chk(32'(n < 100), 32'h1);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk({lowpass_cutoff, delay_ms}, {`DAO_LPF_MAX, `DAO_DLY_MIN_MS});
    chk({out_rate, pro_status, irq, src_lock_en}, {`DAO_RATE_48, 3'h4});
    rdk(`DAO_OFF_CTRL, `DAO_CTRL_RST);
    rdk(`DAO_OFF_FMT, `DAO_FMT_RST);
    rdk(`DAO_OFF_DELAY, `DAO_DELAY_RST);
    rd(8'h20, rdv, rsp);
    chk({rsp, rdv[29:0]}, 32'h8000_0000);
    wr(8'h1C, 32'h5, rsp);
    chk(rsp, 2'h2);
    $display("%0t t_reset done", $time);
  endtask
  task automatic t_ctrl();
    logic [31:0] dv[3] = '{32'h00C8_0780, 32'h0070_08FF, 32'h00C8_0010};
    logic [7:0] lp[3] = '{8'h80, 8'h70, 8'h64};
    logic [5:0] fl[3] = '{6'h37, 6'h0B, 6'h00};
    for (int i = 0; i < 3; i++) begin
      wrk(`DAO_OFF_CTRL, dv[i]);
      cyc(2);
      chk(lowpass_cutoff, lp[i]);
      chk(cfg_bits, fl[i]);
    end
    $display("%0t t_ctrl done", $time);
  endtask
  task automatic t_rate();
    wrk(`DAO_OFF_CTRL, 32'h00C8_00C8);
    for (int i = 0; i < 5; i++) begin
      wrk(`DAO_OFF_FMT, {18'h0, i[0], 10'h0, i[2:0]});
      cyc(2);
      chk(out_rate, i[2:0]);
      chk(lowpass_cutoff, i == 0 ? `DAO_LPF_32K : `DAO_LPF_MAX);
      chk(pro_status, i[0]);
    end
    $display("%0t t_rate done", $time);
  endtask
  task automatic t_delay();
    logic [7:0] ms[7] = '{8'h10, 8'h18, 8'h3C, 8'h50, 8'h20, 8'h2A, 8'h30};
    logic [7:0] ex[7] = '{8'h18, 8'h18, 8'h3C, 8'h3C, 8'h20, 8'h2A, 8'h30};
    for (int i = 0; i < 7; i++) begin
      wrk(`DAO_OFF_DELAY, {16'h0, ms[i], 5'h0, i[2:0]});
      cyc(2);
      chk({delay_mode, delay_ms}, {i < 6 ? i[2:0] : 3'h0, ex[i]});
    end
    $display("%0t t_delay done", $time);
  endtask
  // a short dropout must restart the qualification interval
  task automatic t_sync();
    wrk(`DAO_OFF_FMT, 32'h0000_2012);
    lk1 <= 1'b1;
    cyc(QUAL - 20);
    lk1 <= 1'b0;
    cyc(4);
    lk1 <= 1'b1;
    cyc(QUAL - 5);
    chk(src_lock_en, 1'b0);
    wait_lock(1'b1, 40);
    chk(src_sel, `DAO_SYNC_IN1);
    rdk(`DAO_OFF_ISTAT, 32'h2);
    lk1 <= 1'b0;
    wait_lock(1'b0, 10);
    chk(src_sel, `DAO_SYNC_INT);
    rdk(`DAO_OFF_ISTAT, 32'h3);
    $display("%0t t_sync done", $time);
  endtask
  task automatic t_irq();
    wrk(`DAO_OFF_IMASK, 32'h3);
    cyc(2);
    chk(irq, 1'b1);
    wrk(`DAO_OFF_ISTAT, 32'h1);
    rdk(`DAO_OFF_ISTAT, 32'h2);
    wrk(`DAO_OFF_IMASK, 32'h1);
    cyc(2);
    chk(irq, 1'b0);
    wrk(`DAO_OFF_ISTAT, 32'h2);
    rdk(`DAO_OFF_ISTAT, 32'h0);
    wrk(`DAO_OFF_IMASK, 32'h3);
    $display("%0t t_irq done", $time);
  endtask
  task automatic t_link2();
    r1 <= `DAO_RATE_44;
    lk1 <= 1'b1;
    cyc(2 * QUAL);
    chk(src_lock_en, 1'b0);
    wrk(`DAO_OFF_FMT, 32'h0000_2022);
    lk2 <= 1'b1;
    wait_lock(1'b1, 2 * QUAL);
    chk({src_sel, irq}, {`DAO_SYNC_IN2, 1'b1});
    lk1 <= 1'b0;
    lk2 <= 1'b0;
    wait_lock(1'b0, 10);
    $display("%0t t_link2 done", $time);
  endtask
  task automatic t_word();
    logic [23:0] mk[5] = '{24'hFFFFFF, 24'hFFFFF0, 24'hFFFFC0,
      24'hFFFF00, 24'hFFFC00};
    int nd = 0;
    run <= 1'b1;
    wrk(`DAO_OFF_DATA, 32'h00A5_5A5A);
    for (int i = 0; i < 6; i++) begin
      wrk(`DAO_OFF_FMT, {19'h0, i == 5, 1'b0, i == 5 ? 3'h3 : i[2:0],
        8'h02});
      wait_word();
      wait_word();
      if (i < 5) chk(out_word, 24'hA55A5A & mk[i]);
      else chk(out_word[7:0], 8'h00);
    end
    // with dither in, some words must leave the plain truncated value
    for (int k = 0; k < 4; k++) begin
      wait_word();
      if (out_word !== 24'hA55A00) nd++;
    end
    chk(32'(nd > 0), 32'h1);
    run <= 1'b0;
    $display("%0t t_word done", $time);
  endtask
  // reset for eight cycles, then the scenarios in order
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(2);
    t_reset();
    t_ctrl();
    t_rate();
    t_delay();
    t_sync();
    t_irq();
    t_link2();
    t_word();
    report_and_stop();
  end
  // watchdog well beyond the several hundred cycles the run needs
  initial begin
    #200000;
    n_mismatch++;
    $display("Error at %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule // tb
